/* File: hdl/eem_consts.svh */
// Constants of the two-wire EEPROM lock and read control block
`ifndef EEM_CONSTS_SVH
`define EEM_CONSTS_SVH

// Array geometry
`define EEM_AW 8
`define EEM_DW 8
`define EEM_DEPTH 256
`define EEM_PAGE_W 4

// Device address byte fields
`define EEM_PRE_MSB 7
`define EEM_PRE_LSB 4
`define EEM_ADR_MSB 3
`define EEM_ADR_LSB 1
`define EEM_RW_BIT 0

// Preambles and fixed lock command bytes
`define EEM_PRE_ARRAY 4'hA
`define EEM_PRE_LOCK 4'h6
`define EEM_SET_REV_BYTE 8'h62
`define EEM_READ_REV_BYTE 8'h63
`define EEM_CLR_REV_BYTE 8'h66
`define EEM_STRAP21_SET 2'h0
`define EEM_STRAP21_CLR 2'h1

// Bit slot counts within one nine-clock byte frame
`define EEM_LAST_BIT 4'h7
`define EEM_ACK_SLOT 4'h8

// Upper half starts where the word address MSB is set
`define EEM_UPPER_BIT 7

// Reset and filler values
`define EEM_FLAG_RST 1'h0
`define EEM_ADDR_RST 8'h00
`define EEM_BYTE_RST 8'h00
`define EEM_CNT_RST 4'h0
`define EEM_FILLER 8'hFF

`endif

/* File: hdl/eem_pkg.sv */
// Types shared by the EEPROM lock and read control block
package eem_pkg;

    `include "eem_consts.svh"

    // Command classes recognised in the device address byte
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_ARRAY,
        CMD_SET_PERM,
        CMD_READ_PERM,
        CMD_SET_REV,
        CMD_READ_REV,
        CMD_CLR_REV
    } eem_cmd_e;

    // Byte level protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADR,
        ST_WORDADR,
        ST_WDATA,
        ST_IGNORE,
        ST_RDATA
    } eem_state_e;

    // Static pins, synchronised together
    typedef struct packed {
        logic wp;
        logic hv;
        logic [2:0] strap;
    } eem_pins_s;

    // Serial line pair as seen in the system domain
    typedef struct packed {
        logic scl;
        logic sda;
    } eem_line_s;

    // Result of decoding a device address byte
    typedef struct packed {
        eem_cmd_e cmd;
        logic ack;
        logic rd;
    } eem_dec_s;

endpackage

/* File: hdl/eem_mem.sv */
// 256 x 8 storage array with registered read data
`timescale 1ns/1ps
`include "eem_consts.svh"
module eem_mem (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] raddr,
    output logic [7:0] rdata_q
);
    import eem_pkg::*;

    logic [`EEM_DW-1:0] mem [0:`EEM_DEPTH-1];

    // Contents survive the block reset, as a nonvolatile array would
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data always follows the current address one cycle later
    always_ff @(posedge clk_sys) begin
        rdata_q <= mem[raddr];
    end
endmodule

/* File: hdl/eem_lock_ctrl.sv */
// Two-wire EEPROM slave: lock flags, write gating and array reads
//
// Behaviour
// - lock commands use preamble 0110, array 1010
// - address bits must match the strap pins
// - 01100010 with straps 0,0,high voltage sets lock
// - 01100110 with straps 0,1,high voltage clears lock
// - unprotected set-permanent command acked and programmed
// - permanent lock blocks its read, set, clear
// - unprotected set-reversible command acked and programmed
// - reversible lock blocks its read and set
// - unprotected clear acked, reversible flag cleared
// - unprogrammed status read acked, data meaningless
// - any lock limits writes to upper half
// - no lock, writes reach the whole array
// - protect pin high: writes acked, array unchanged
// - protect pin high: set commands change nothing
// - protect pin high: clear acked, flag unchanged
// - read selected by final address bit one
// - address counter holds last address plus one
// - read counter wraps from last to first byte
// - read shifts out byte at counter address
// - random read returns byte at loaded address
`timescale 1ns/1ps
`include "eem_consts.svh"
module eem_lock_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic wp_pin,
    input wire logic strap_pin_0,
    input wire logic strap_pin_1,
    input wire logic strap_pin_2,
    input wire logic high_voltage_level,
    output logic permanent_lower_lock_flag,
    output logic reversible_lower_lock_flag,
    output logic link_busy
);
    import eem_pkg::*;

    // Synchronisers and edge history
    eem_line_s line_meta_q;
    eem_line_s line_q;
    eem_line_s line_prev_q;
    eem_pins_s pins_meta_q;
    eem_pins_s pins_q;

    // Protocol state
    eem_state_e state_q;
    eem_state_e nxt_q;
    eem_cmd_e cmd_q;
    eem_cmd_e pend_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q;
    logic [7:0] tx_q;
    logic [7:0] addr_q;
    logic want_q;
    logic perm_q;
    logic rev_q;
    logic busy_q;

    // Link side drive flops
    logic sda_oe_q;
    logic sda_o_q;

    // Combinational helpers
    logic rise;
    logic start_ev;
    logic stop_ev;
    logic active;
    logic byte_done;
    logic ack_slot;
    logic master_nack;
    logic go_tx;
    logic [7:0] sr_next;
    logic [7:0] tx_src;
    logic [7:0] mem_rdata;
    logic mem_we;
    logic wr_allowed;
    eem_dec_s dec;

    // Classifies a device address byte and decides the acknowledge
    function automatic eem_dec_s decode_cmd(
        input logic [7:0] b,
        input eem_pins_s p,
        input logic perm,
        input logic rev
    );
        eem_dec_s r;
        logic strap_ok;
        r.cmd = CMD_NONE;
        r.ack = 1'b0;
        r.rd = b[`EEM_RW_BIT];
        strap_ok = (b[`EEM_ADR_MSB:`EEM_ADR_LSB] == p.strap);
        if (b[`EEM_PRE_MSB:`EEM_PRE_LSB] == `EEM_PRE_ARRAY) begin
            if (strap_ok) begin
                // Array access is always acknowledged, even protected
                r.cmd = CMD_ARRAY;
                r.ack = 1'b1;
            end
        end else if (b[`EEM_PRE_MSB:`EEM_PRE_LSB] == `EEM_PRE_LOCK) begin
            if (p.hv && strap_ok) begin
                // High voltage on strap 0 selects the reversible flag
                if (p.strap[2:1] == `EEM_STRAP21_SET &&
                    b == `EEM_SET_REV_BYTE) begin
                    r.cmd = CMD_SET_REV;
                    r.ack = !rev;
                end else if (p.strap[2:1] == `EEM_STRAP21_SET &&
                    b == `EEM_READ_REV_BYTE) begin
                    r.cmd = CMD_READ_REV;
                    r.ack = !rev;
                end else if (p.strap[2:1] == `EEM_STRAP21_CLR &&
                    b == `EEM_CLR_REV_BYTE) begin
                    r.cmd = CMD_CLR_REV;
                    r.ack = !perm;
                end
            end else if (!p.hv && strap_ok) begin
                // Normal levels address the permanent flag
                r.cmd = b[`EEM_RW_BIT] ? CMD_READ_PERM : CMD_SET_PERM;
                r.ack = !perm;
            end
        end
        return r;
    endfunction

    // Two flip-flops on the line and static pins before system-clock logic sees them; scl_clk also clocks the link flops directly
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_meta_q <= '1;
            line_q <= '1;
            line_prev_q <= '1;
            pins_meta_q <= '0;
            pins_q <= '0;
        end else begin
            line_meta_q <= '{scl: scl_clk, sda: sda_i};
            line_q <= line_meta_q;
            line_prev_q <= line_q;
            pins_meta_q <= '{wp: wp_pin, hv: high_voltage_level,
                strap: {strap_pin_2, strap_pin_1, strap_pin_0}};
            pins_q <= pins_meta_q;
        end
    end

    // Line events; both lines share the same sync delay, so skew is even
    assign rise = line_q.scl && !line_prev_q.scl;
    assign start_ev = line_q.scl && line_prev_q.scl &&
        line_prev_q.sda && !line_q.sda;
    assign stop_ev = line_q.scl && line_prev_q.scl &&
        !line_prev_q.sda && line_q.sda;
    assign active = (state_q != ST_IDLE);
    assign byte_done = rise && active && (cnt_q == `EEM_LAST_BIT);
    assign ack_slot = rise && active && (cnt_q == `EEM_ACK_SLOT);
    assign sr_next = {sr_q[6:0], line_q.sda};
    assign master_nack = (state_q == ST_RDATA) && line_q.sda;
    assign go_tx = ack_slot && (nxt_q == ST_RDATA) && !master_nack;
    assign dec = decode_cmd(sr_next, pins_q, perm_q, rev_q);

    // Lock status reads clock out filler; only the ack carries meaning
    assign tx_src = (cmd_q == CMD_ARRAY) ? mem_rdata : `EEM_FILLER;

    // Lower half is closed by either lock, whole array by the pin
    assign wr_allowed = !pins_q.wp &&
        (addr_q[`EEM_UPPER_BIT] || !(perm_q || rev_q));
    assign mem_we = byte_done && (state_q == ST_WDATA) && wr_allowed;

    // Bit slot counter: eight data slots then the acknowledge slot
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `EEM_CNT_RST;
        end else if (start_ev || stop_ev) begin
            cnt_q <= `EEM_CNT_RST;
        end else if (rise && active) begin
            if (cnt_q == `EEM_ACK_SLOT) begin
                cnt_q <= `EEM_CNT_RST;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // Receive shift register samples data on the clock rise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= `EEM_BYTE_RST;
        end else if (rise && active && cnt_q < `EEM_ACK_SLOT) begin
            sr_q <= sr_next;
        end
    end

    // Byte level sequence; a start always wins over a byte in flight
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            cmd_q <= CMD_NONE;
        end else if (start_ev) begin
            state_q <= ST_DEVADR;
            nxt_q <= ST_IDLE;
            cmd_q <= CMD_NONE;
        end else if (stop_ev) begin
            state_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
        end else if (byte_done) begin
            unique case (state_q)
                ST_DEVADR: begin
                    cmd_q <= dec.cmd;
                    if (!dec.ack) begin
                        nxt_q <= ST_IDLE;
                    end else if (dec.rd) begin
                        nxt_q <= ST_RDATA;
                    end else if (dec.cmd == CMD_ARRAY) begin
                        nxt_q <= ST_WORDADR;
                    end else begin
                        nxt_q <= ST_IGNORE;
                    end
                end
                ST_WORDADR: nxt_q <= ST_WDATA;
                ST_WDATA: nxt_q <= ST_WDATA;
                ST_IGNORE: nxt_q <= ST_IGNORE;
                ST_RDATA: nxt_q <= ST_RDATA;
                ST_IDLE: nxt_q <= ST_IDLE;
            endcase
        end else if (ack_slot) begin
            // A read ended by the master waits idle for its stop
            state_q <= master_nack ? ST_IDLE : nxt_q;
        end
    end

    // Word address counter shared by reads and writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= `EEM_ADDR_RST;
        end else if (byte_done) begin
            if (state_q == ST_WORDADR) begin
                addr_q <= sr_next;
            end else if (state_q == ST_WDATA) begin
                // Writes roll over inside the current page
                addr_q <= {addr_q[7:`EEM_PAGE_W],
                    addr_q[`EEM_PAGE_W-1:0] + 4'h1};
            end else if (state_q == ST_RDATA && cmd_q == CMD_ARRAY) begin
                // Natural 8-bit wrap takes FFH back to 00H
                addr_q <= addr_q + 8'h01;
            end
        end
    end

    // Transmit shifter, loaded in the acknowledge slot before a data byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= `EEM_BYTE_RST;
        end else if (go_tx) begin
            tx_q <= tx_src;
        end else if (rise && state_q == ST_RDATA &&
            cnt_q < `EEM_LAST_BIT) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Pull-low request for the next low phase, decided while the clock
    // is high so the link flop can launch it on the falling edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            want_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            want_q <= 1'b0;
        end else if (byte_done) begin
            unique case (state_q)
                ST_DEVADR: want_q <= dec.ack;
                ST_RDATA: want_q <= 1'b0;
                ST_IDLE: want_q <= 1'b0;
                default: want_q <= 1'b1;
            endcase
        end else if (ack_slot) begin
            want_q <= go_tx ? !tx_src[7] : 1'b0;
        end else if (rise && state_q == ST_RDATA &&
            cnt_q < `EEM_LAST_BIT) begin
            want_q <= !tx_q[6];
        end
    end

    // Lock command waiting for its stop; cleared by any new start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= CMD_NONE;
        end else if (start_ev || stop_ev) begin
            pend_q <= CMD_NONE;
        end else if (byte_done && state_q == ST_DEVADR && dec.ack &&
            !dec.rd && dec.cmd != CMD_ARRAY) begin
            pend_q <= dec.cmd;
        end
    end

    // Lock flags change only at the stop, and never with the pin high.
    // The reset stands in for power-up, so it returns both flags clear.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            perm_q <= `EEM_FLAG_RST;
            rev_q <= `EEM_FLAG_RST;
        end else if (stop_ev && !pins_q.wp) begin
            if (pend_q == CMD_SET_PERM) begin
                perm_q <= 1'b1;
            end
            if (pend_q == CMD_SET_REV) begin
                rev_q <= 1'b1;
            end else if (pend_q == CMD_CLR_REV) begin
                rev_q <= 1'b0;
            end
        end
    end

    // Frame activity for the outside world
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= active;
        end
    end

    // Data changes only while the clock is low, so the request is
    // launched on the falling edge; it is stable across that edge
    // because it was settled well inside the preceding high phase.
    always_ff @(negedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_q <= 1'b0;
            sda_o_q <= 1'b0;
        end else begin
            sda_oe_q <= want_q;
            sda_o_q <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_q;
    assign sda_o = sda_o_q;
    assign permanent_lower_lock_flag = perm_q;
    assign reversible_lower_lock_flag = rev_q;
    assign link_busy = busy_q;

    // Storage array
    eem_mem u_mem (
        .clk_sys(clk_sys),
        .we(mem_we),
        .waddr(addr_q),
        .wdata(sr_next),
        .raddr(addr_q),
        .rdata_q(mem_rdata)
    );
endmodule

/* File: bench/eem_lock_ctrl_props.sv */
// Concurrent checks on the ports of the two-wire lock block
`timescale 1ns/1ps
module eem_lock_ctrl_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic wp_pin,
    input wire logic strap_pin_0,
    input wire logic strap_pin_1,
    input wire logic strap_pin_2,
    input wire logic high_voltage_level,
    input wire logic permanent_lower_lock_flag,
    input wire logic reversible_lower_lock_flag,
    input wire logic link_busy
);
    wire perm = permanent_lower_lock_flag;
    wire rev = reversible_lower_lock_flag;
    wire hv = high_voltage_level;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Start: data falls while the serial clock stays high
    sequence s_start;
        scl_clk && $past(scl_clk) && $fell(sda_i);
    endsequence
    // Flags move only just after a frame taken with the protect pin low
    sequence s_commit;
        $past(link_busy, 8) && !$past(wp_pin, 8);
    endsequence

    a_idle_no_drive: assert property (!link_busy [*4] |-> !sda_oe)
        else $error("data driven while link idle");
    a_quiet_addr: assert property (
        $rose(link_busy) |-> (!sda_oe) [*8])
        else $error("data driven before address byte ended");
    a_oe_steady_high: assert property (
        scl_clk && $past(scl_clk) && $stable(sda_i) |-> $stable(sda_oe))
        else $error("data drive moved while clock high");
    a_start_busy: assert property (s_start |-> ##[1:8] link_busy)
        else $error("start not taken");
    a_perm_sticky: assert property (perm |=> perm)
        else $error("permanent lock flag cleared");
    a_perm_cause: assert property (
        $rose(perm) |-> s_commit ##0 !$past(hv, 8))
        else $error("permanent lock set without its command");
    a_rev_set_cause: assert property (
        $rose(rev) |-> s_commit ##0 ($past(hv, 8)
        && !$past(strap_pin_1, 8) && !$past(strap_pin_2, 8)))
        else $error("reversible lock set without its command");
    a_rev_clr_cause: assert property (
        $fell(rev) |-> s_commit ##0 ($past(strap_pin_1, 8) && !perm))
        else $error("reversible lock cleared without its command");
endmodule

/* File: bench/eem_master.sv */
// Two-wire bus master model for the serial clock and data lines
`timescale 1ns/1ps
module eem_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One bit slot: data moves mid low time, sampled mid high time
    task automatic slot(input logic b, output logic s);
        #31 sda_low = !b;
        #31 scl = 1'b1;
        #31 s = sda;
        #32 scl = 1'b0;
    endtask
    // Start or repeated start; leaves the clock low
    task automatic start();
        #31 sda_low = 1'b0;
        #31 scl = 1'b1;
        #31 sda_low = 1'b1;
        #32 scl = 1'b0;
    endtask
    // Stop, then the clock stays driven high and data is left to the pull-up
    task automatic stop();
        #31 sda_low = 1'b1;
        #31 scl = 1'b1;
        #31 sda_low = 1'b0;
        #31;
    endtask
    // Byte out MSB first, line released for the acknowledge slot
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(b[i], s);
        end
        slot(1'b1, s);
        ack = !s;
    endtask
    // Byte in; the last byte is refused so a stop may follow
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, s);
            d[i] = s;
        end
        slot(!more, s);
    endtask
endmodule

/* File: bench/test_eem_lock_ctrl.sv */
// Self-checking bench for the two-wire lock and read block
`timescale 1ns/1ps
module test_eem_lock_ctrl;
    logic clk_sys, rst_n, scl, m_low, wp, hv, ack, sda_o, sda_oe;
    logic perm_f, rev_f, busy, perm_r, rev_r;
    logic [2:0] st;
    logic [7:0] ptr, d;
    logic [7:0] mem_r [256];
    logic [7:0] adr [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
    int n_errors, tests_run, seed;
    wire sda;

    // Pull-up on the data line; either party may pull it low
    assign sda = !((sda_oe && !sda_o) || m_low);

    eem_lock_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_clk(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp_pin(wp),
        .strap_pin_0(st[0]), .strap_pin_1(st[1]), .strap_pin_2(st[2]),
        .high_voltage_level(hv), .permanent_lower_lock_flag(perm_f),
        .reversible_lower_lock_flag(rev_f), .link_busy(busy));
    eem_master m (.scl(scl), .sda_low(m_low), .sda(sda));

    // System clock, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end

    // Compare helpers count every check and report mismatches
    task automatic chk8(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    // Static pins change at the falling edge, well before a frame
    task automatic pins(input logic [2:0] s, input logic h, w);
        @(negedge clk_sys);
        st = s;
        hv = h;
        wp = w;
    endtask

    // Writes land if unprotected, upper half only under a lock
    function automatic logic wr_ok(input logic [7:0] a);
        return !wp && (a[7] || !(perm_r || rev_r));
    endfunction

    // Array device address with the straps as currently wired
    task automatic dev(input logic r, input logic e);
        m.start();
        m.wbyte({4'hA, st, r}, ack);
        chk1("dev ack", e, ack);
    endtask
    task automatic wr(input logic [7:0] a, v);
        dev(1'b0, 1'b1);
        m.wbyte(a, ack);
        m.wbyte(v, ack);
        chk1("data ack", 1'b1, ack);
        m.stop();
        if (wr_ok(a))
            mem_r[a] = v;
    endtask
    // Random read uses a dummy write; current read uses the counter
    task automatic rd(input logic [7:0] a, input logic rnd);
        if (rnd) begin
            dev(1'b0, 1'b1);
            m.wbyte(a, ack);
            ptr = a;
        end
        dev(1'b1, 1'b1);
        m.rbyte(1'b0, d);
        m.stop();
        chk8("read data", mem_r[ptr], d);
        ptr++;
    endtask
    // Boundary writes, read back, then a current read past FFH
    task automatic sweep();
        foreach (adr[i]) begin
            pins(3'($random(seed)), 1'b0, wp);
            wr(adr[i], 8'($random(seed)));
        end
        foreach (adr[i])
            rd(adr[i], 1'b1);
        rd(8'h00, 1'b0);
    endtask

    // Lock command; flags settle a few cycles after the stop
    task automatic lock(input logic [7:0] b, input logic h);
        logic e;
        pins(b[3:1], h, wp);
        e = (b[3:1] == 3'h1 && h) ? !rev_r : !perm_r;
        m.start();
        m.wbyte(b, ack);
        chk1("lock ack", e, ack);
        if (ack && b[0])
            m.rbyte(1'b0, d);
        m.stop();
        #100;
        if (ack && !wp && !b[0]) begin
            if (!h)
                perm_r = 1'b1;
            else
                rev_r = !b[2];
        end
        chk1("perm flag", perm_r, perm_f);
        chk1("rev flag", rev_r, rev_f);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        seed = 32'hB8416088;
        n_errors = 0;
        tests_run = 0;
        {rst_n, wp, hv, st, perm_r, rev_r, ptr} = '0;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk1("perm flag", 1'b0, perm_f);
        sweep();
        $display("test open writes done");
        pins(st, 1'b0, 1'b1);
        sweep();
        lock(8'h62, 1'b1);
        lock(8'h66, 1'b1);
        lock(8'h6A, 1'b0);
        $display("test protect pin done");
        pins(st, 1'b0, 1'b0);
        lock(8'h63, 1'b1);
        lock(8'h62, 1'b1);
        lock(8'h63, 1'b1);
        lock(8'h62, 1'b1);
        sweep();
        lock(8'h66, 1'b1);
        sweep();
        $display("test reversible lock done");
        lock(8'h65, 1'b0);
        lock(8'h64, 1'b0);
        lock(8'h65, 1'b0);
        lock(8'h64, 1'b0);
        lock(8'h66, 1'b1);
        lock(8'h62, 1'b1);
        sweep();
        $display("test permanent lock done");
        pins(3'h5, 1'b0, 1'b0);
        m.start();
        m.wbyte({4'hA, ~st, 1'b0}, ack);
        m.stop();
        chk1("strap mismatch ack", 1'b0, ack);
        $display("test strap mismatch done");
        // Power-up again: flags clear, array kept, counter back at 00H
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        {perm_r, rev_r, ptr} = '0;
        repeat (4) @(negedge clk_sys);
        chk1("perm flag", 1'b0, perm_f);
        chk1("rev flag", 1'b0, rev_f);
        rd(8'h00, 1'b0);
        sweep();
        $display("test power up done");
        conclude();
    end

    // Watchdog well past the expected run length
    initial begin
        #400000;
        n_errors++;
        conclude();
    end
endmodule

bind eem_lock_ctrl eem_lock_ctrl_props u_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .wp_pin(wp_pin), .strap_pin_0(strap_pin_0),
    .strap_pin_1(strap_pin_1), .strap_pin_2(strap_pin_2),
    .high_voltage_level(high_voltage_level),
    .permanent_lower_lock_flag(permanent_lower_lock_flag),
    .reversible_lower_lock_flag(reversible_lower_lock_flag),
    .link_busy(link_busy));
